// ==== rtl/mirror_ctrl_pkg.sv ====
package mirror_ctrl_pkg;

	typedef enum logic [1:0] {MODE_OFF, MODE_ON, MODE_AUTO} mode_t;
	typedef enum logic [1:0] {CL_IDLE, CL_SPRAY, CL_SPIN} clean_state_t;

	// clock and one-second tick
	localparam int unsigned CLK_FREQ_HZ = 250_000_000;
	localparam int unsigned TICK_PERIOD_S = 1;
	localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_S * CLK_FREQ_HZ;
	localparam int unsigned TICK_CNT_W = 28;

	// cleaner timing, in seconds
	localparam logic [6:0] SPIN_TAIL_S = 7'h0A;
	localparam logic [6:0] SPRAY_MAX_S = 7'h6E;
	localparam logic [16:0] SEC_PER_MIN = 17'h0003C;

	// percentages and pulse-width period
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam logic [6:0] PWM_LAST_STEP = 7'h63;

	// temperature is signed, 1/16 degC per count; offset is whole degC
	localparam int unsigned TEMP_W = 12;
	localparam int unsigned TEMP_FRAC_BITS = 4;

	// time of day
	localparam logic [10:0] MIN_PER_HOUR = 11'h03C;

	function automatic logic [10:0] hm_to_min(input logic [4:0] hh, input logic [5:0] mm);
		hm_to_min = 11'(hh) * MIN_PER_HOUR + 11'(mm);
	endfunction

	// equal start and stop means the whole day; stop before start wraps midnight
	function automatic logic in_window(input logic [10:0] now, input logic [10:0] t_start,
		input logic [10:0] t_stop);
		if (t_start == t_stop) begin
			in_window = 1'b1;
		end else if (t_start < t_stop) begin
			in_window = (now >= t_start) && (now < t_stop);
		end else begin
			in_window = (now >= t_start) || (now < t_stop);
		end
	endfunction

endpackage

// ==== rtl/heat_pwm_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface heat_pwm_if;
	logic en;
	logic [6:0] duty;
	logic out;
	modport ctrl (output en, output duty, input out);
	modport pwm (input en, input duty, output out);
endinterface
`default_nettype wire

// ==== rtl/heat_pwm.sv ====
`timescale 1ns/10ps
`default_nettype none
module heat_pwm
	import mirror_ctrl_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	heat_pwm_if.pwm chan
);
	logic [6:0] step_reg;
	logic out_reg;
	wire last_step = (step_reg == PWM_LAST_STEP);
	wire on_now = chan.en && (step_reg < chan.duty);

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			step_reg <= 7'h00;
			out_reg <= 1'b0;
		end else begin
			step_reg <= last_step ? 7'h00 : step_reg + 7'h01;
			out_reg <= on_now;
		end
	end

	assign chan.out = out_reg;

	a_off_stays_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		!chan.en |=> !out_reg) else $error("heater pulse while channel disabled");
endmodule
`default_nettype wire

// ==== rtl/mirror_heater_cleaner_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module mirror_heater_cleaner_ctrl
	import mirror_ctrl_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [10:0] i_tod_min,
	input wire logic [6:0] i_rssi_pct,
	input wire logic signed [TEMP_W-1:0] i_ambient_temp,
	input wire logic signed [TEMP_W-1:0] i_upper_mirror_temp,
	input wire mode_t i_upper_mode,
	input wire logic [6:0] i_upper_power_pct,
	input wire logic [4:0] i_upper_offset_c,
	input wire logic [4:0] i_upper_start_hh,
	input wire logic [5:0] i_upper_start_mm,
	input wire logic [4:0] i_upper_stop_hh,
	input wire logic [5:0] i_upper_stop_mm,
	input wire mode_t i_lower_mode,
	input wire logic [6:0] i_lower_power_pct,
	input wire logic [6:0] i_lower_thresh_pct,
	input wire logic [4:0] i_lower_start_hh,
	input wire logic [5:0] i_lower_start_mm,
	input wire logic [4:0] i_lower_stop_hh,
	input wire logic [5:0] i_lower_stop_mm,
	input wire mode_t i_clean_mode,
	input wire logic [6:0] i_clean_thresh_pct,
	input wire logic [4:0] i_clean_start_hh,
	input wire logic [5:0] i_clean_start_mm,
	input wire logic [4:0] i_clean_stop_hh,
	input wire logic [5:0] i_clean_stop_mm,
	input wire logic [4:0] i_repeat_hh,
	input wire logic [5:0] i_repeat_mm,
	input wire logic [6:0] i_spray_s,
	output logic o_heat_upper,
	output logic o_heat_lower,
	output logic o_pump,
	output logic o_spin,
	output logic o_clean_busy
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	////////////////////////////////////////////////////////////////////////
	// one-second tick
	logic [TICK_CNT_W-1:0] tick_cnt_reg;
	logic tick;
	assign tick = (tick_cnt_reg == TICK_CNT_W'(TICK_CYCLES - 1));

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TICK_CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// heaters
	// wrap past midnight
	wire upper_win = in_window(i_tod_min, hm_to_min(i_upper_start_hh, i_upper_start_mm),
		hm_to_min(i_upper_stop_hh, i_upper_stop_mm));
	wire lower_win = in_window(i_tod_min, hm_to_min(i_lower_start_hh, i_lower_start_mm),
		hm_to_min(i_lower_stop_hh, i_lower_stop_mm));
	wire signed [TEMP_W+1:0] upper_setpoint = (TEMP_W+2)'(i_ambient_temp)
		+ (TEMP_W+2)'({i_upper_offset_c, TEMP_FRAC_BITS'(0)});
	wire upper_cold = ((TEMP_W+2)'(i_upper_mirror_temp) < upper_setpoint);
	wire lower_low_sig = (i_rssi_pct < i_lower_thresh_pct);
	wire [6:0] upper_duty = (i_upper_power_pct > PCT_FULL) ? PCT_FULL : i_upper_power_pct;
	wire [6:0] lower_duty = (i_lower_power_pct > PCT_FULL) ? PCT_FULL : i_lower_power_pct;
	// on mode ignores window; auto adds window
	wire upper_en = ((i_upper_mode == MODE_ON) && upper_cold)
		|| ((i_upper_mode == MODE_AUTO) && upper_cold && upper_win);
	// lower auto gated by signal and window; on mode ignores both
	wire lower_en = (i_lower_mode == MODE_ON)
		|| ((i_lower_mode == MODE_AUTO) && lower_low_sig && lower_win);

	heat_pwm_if upper_if ();
	heat_pwm_if lower_if ();
	assign upper_if.en = upper_en;
	assign upper_if.duty = upper_duty;
	assign lower_if.en = lower_en;
	assign lower_if.duty = lower_duty;

	heat_pwm u_upper_pwm (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.chan(upper_if.pwm)
	);
	heat_pwm u_lower_pwm (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.chan(lower_if.pwm)
	);
	assign o_heat_upper = upper_if.out;
	assign o_heat_lower = lower_if.out;

	////////////////////////////////////////////////////////////////////////
	// cleaner
	clean_state_t state_reg, state_next;
	logic [6:0] sec_reg, sec_next;
	logic [6:0] spray_len_reg;
	logic [16:0] chk_reg;
	logic win_prev_reg;
	logic pump_reg, spin_reg;

	wire clean_win = in_window(i_tod_min, hm_to_min(i_clean_start_hh, i_clean_start_mm),
		hm_to_min(i_clean_stop_hh, i_clean_stop_mm));
	wire [16:0] repeat_s = 17'(hm_to_min(i_repeat_hh, i_repeat_mm)) * SEC_PER_MIN;
	wire win_entry = clean_win && !win_prev_reg;
	wire interval_due = tick && clean_win && (repeat_s != 17'h00000) && (chk_reg == repeat_s - 17'h00001);
	wire clean_low_sig = (i_rssi_pct < i_clean_thresh_pct);
	wire auto_go = (i_clean_mode == MODE_AUTO) && clean_low_sig && (win_entry || interval_due);
	// checks that land while a cycle runs are dropped; the next interval retries
	wire clean_start = (state_reg == CL_IDLE) && ((i_clean_mode == MODE_ON) || auto_go);
	wire [6:0] spray_req = (i_spray_s > SPRAY_MAX_S) ? SPRAY_MAX_S : i_spray_s;
	wire clean_off = (i_clean_mode != MODE_ON) && (i_clean_mode != MODE_AUTO);

	always_comb begin
		state_next = state_reg;
		sec_next = sec_reg;
		unique case (state_reg)
			CL_IDLE: begin
				if (clean_start) begin
					sec_next = 7'h00;
					// zero spray goes straight to spin
					state_next = (spray_req == 7'h00) ? CL_SPIN : CL_SPRAY;
				end
			end
			CL_SPRAY: begin
				if (tick) begin
					sec_next = sec_reg + 7'h01;
					if (sec_reg == spray_len_reg - 7'h01) begin
						sec_next = 7'h00;
						state_next = CL_SPIN;
					end
				end
			end
			CL_SPIN: begin
				if (tick) begin
					sec_next = sec_reg + 7'h01;
					if (sec_reg == SPIN_TAIL_S - 7'h01) begin
						state_next = CL_IDLE;
					end
				end
			end
			default: begin
				state_next = CL_IDLE;
			end
		endcase
		if (clean_off) begin
			state_next = CL_IDLE;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= CL_IDLE;
			sec_reg <= 7'h00;
			spray_len_reg <= 7'h00;
			chk_reg <= 17'h00000;
			win_prev_reg <= 1'b0;
			pump_reg <= 1'b0;
			spin_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sec_reg <= sec_next;
			win_prev_reg <= clean_win;
			if (clean_start) begin
				spray_len_reg <= spray_req;
			end
			if (!clean_win || win_entry || interval_due) begin
				chk_reg <= 17'h00000;
			end else if (tick) begin
				chk_reg <= chk_reg + 17'h00001;
			end
			pump_reg <= (state_next == CL_SPRAY);
			spin_reg <= (state_next != CL_IDLE);
		end
	end

	assign o_pump = pump_reg;
	assign o_spin = spin_reg;
	assign o_clean_busy = spin_reg;

	////////////////////////////////////////////////////////////////////////
	// checks
	a_tick_spacing: assert property (tick |-> ##1 !tick [*2] or ##1 (TICK_CYCLES < 3))
		else $error("second tick arrived too early");
	a_pump_with_spin: assert property (o_pump |-> o_spin)
		else $error("pump running without spin motor");
	a_tail_length: assert property ($fell(o_spin) && !$past(clean_off)
		|-> $past(sec_reg, 2) == SPIN_TAIL_S - 7'h01) else $error("spin tail not ten seconds");
	a_zero_no_pump: assert property ((spray_len_reg == 7'h00) |-> !o_pump)
		else $error("pump on with zero spray duration");
	a_spray_range: assert property (spray_len_reg <= SPRAY_MAX_S)
		else $error("spray duration above limit");
	a_auto_start_gate: assert property (clean_start && (i_clean_mode == MODE_AUTO)
		|-> clean_low_sig && clean_win ##1 o_spin) else $error("auto clean started without cause");
	a_lower_sig_gate: assert property ((i_lower_mode == MODE_AUTO) && !lower_low_sig
		|=> !o_heat_lower) else $error("lower heater on above threshold");
	a_upper_win_gate: assert property ((i_upper_mode == MODE_AUTO) && !upper_win
		|=> !o_heat_upper) else $error("upper heater on outside window");
	a_clean_off_low: assert property (clean_off |=> !o_pump && !o_spin)
		else $error("cleaner active in off mode");
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
	import mirror_ctrl_pkg::*;
	logic clk, rst_b;
	logic [10:0] tod;
	logic [6:0] rssi, upw, lpw, lthr, cthr, spray;
	logic signed [TEMP_W-1:0] amb, mir;
	mode_t um, lm, cm;
	logic [4:0] uoff, ush, uph, lsh, lph, csh, cph, rph;
	logic [5:0] usm, upm, lsm, lpm, csm, cpm, rpm;
	logic hu, hl, pump, spin, busy;
	int fail_count, total_checks;
	// four-state counters so an unknown output cannot pass as zero
	integer n_hu, n_hl, n_pump, n_spin, n_busy, n_rise;

	// short tick keeps cleaner timing within a few thousand cycles
	mirror_heater_cleaner_ctrl #(.TICK_CYCLES(10)) mirror_heater_cleaner_ctrl_inst (
		.i_ref_clk(clk), .i_rst_b(rst_b), .i_tod_min(tod), .i_rssi_pct(rssi),
		.i_ambient_temp(amb), .i_upper_mirror_temp(mir), .i_upper_mode(um),
		.i_upper_power_pct(upw), .i_upper_offset_c(uoff), .i_upper_start_hh(ush),
		.i_upper_start_mm(usm), .i_upper_stop_hh(uph), .i_upper_stop_mm(upm),
		.i_lower_mode(lm), .i_lower_power_pct(lpw), .i_lower_thresh_pct(lthr),
		.i_lower_start_hh(lsh), .i_lower_start_mm(lsm), .i_lower_stop_hh(lph),
		.i_lower_stop_mm(lpm), .i_clean_mode(cm), .i_clean_thresh_pct(cthr),
		.i_clean_start_hh(csh), .i_clean_start_mm(csm), .i_clean_stop_hh(cph),
		.i_clean_stop_mm(cpm), .i_repeat_hh(rph), .i_repeat_mm(rpm), .i_spray_s(spray),
		.o_heat_upper(hu), .o_heat_lower(hl), .o_pump(pump), .o_spin(spin), .o_clean_busy(busy));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %0d, seen %0d", name, exp, seen);
		end
	endtask

	// counts high cycles of every output, sampled at the falling edge where they are settled
	task automatic run(input int n);
		logic prev;
		prev = spin;
		{n_hu, n_hl, n_pump, n_spin, n_busy, n_rise} = '0;
		repeat (n) begin
			@(negedge clk);
			n_hu += hu;
			n_hl += hl;
			n_pump += pump;
			n_spin += spin;
			n_busy += busy;
			n_rise += (spin && !prev);
			prev = spin;
		end
	endtask

	task automatic do_reset();
		rst_b = 1'b0;
		repeat (5) @(negedge clk);
		check("outputs in reset", {hu, hl, pump, spin, busy}, 0);
		rst_b = 1'b1;
	endtask

	// a fresh window entry: leave the cleaner window, then step into it at 01:00
	task automatic arm();
		tod = 11'h000;
		run(3);
		tod = 11'h03C;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_power();
		int p[5] = '{0, 7, 50, 100, 127};
		run(200);
		check("heaters off", n_hu + n_hl, 0);
		lm = MODE_ON;
		tod = 11'h2D0;
		foreach (p[i]) begin
			lpw = 7'(p[i]);
			run(3);
			run(100);
			check("o_heat_lower duty", n_hl, p[i] > 100 ? 100 : p[i]);
		end
		um = MODE_ON;
		run(3);
		run(100);
		check("o_heat_upper on", n_hu, 7);
	endtask

	task automatic t_heat_auto();
		int t[4] = '{11'h564, 11'h438, 11'h168, 11'h2D0};
		int e[4] = '{7, 7, 0, 0};
		um = MODE_AUTO;
		lm = MODE_AUTO;
		lpw = 7'h07;
		foreach (t[i]) begin
			tod = 11'(t[i]);
			run(3);
			run(100);
			check("o_heat_upper window", n_hu, e[i]);
			check("o_heat_lower window", n_hl, e[i]);
		end
		tod = 11'h564;
		rssi = 7'h28;
		mir = 12'h11F;
		run(3);
		run(100);
		check("o_heat_lower strong signal", n_hl, 0);
		check("o_heat_upper just cold", n_hu, 7);
		mir = 12'h130;
		run(3);
		run(100);
		check("o_heat_upper warm", n_hu, 0);
	endtask

	task automatic t_cycle();
		int s[4] = '{0, 2, 110, 127};
		int k;
		cm = MODE_AUTO;
		rssi = 7'h0A;
		foreach (s[i]) begin
			spray = 7'(s[i]);
			k = s[i] > 110 ? 110 : s[i];
			arm();
			run(1400);
			check("o_pump length", n_pump >= (k > 0 ? k * 10 - 9 : 0) && n_pump <= k * 10, 1);
			check("spin tail", n_spin - n_pump >= (k > 0 ? 99 : 90) && n_spin - n_pump <= 101, 1);
			check("o_clean_busy", n_busy, n_spin);
			check("cycles", n_rise, 1);
		end
	endtask

	task automatic t_thresh();
		spray = 7'h02;
		rssi = 7'h14;
		arm();
		run(300);
		check("start at threshold", n_rise, 0);
		rssi = 7'h0A;
		tod = 11'h000;
		run(3);
		tod = 11'h0C8;
		run(300);
		check("start outside window", n_rise, 0);
	endtask

	task automatic t_repeat();
		spray = 7'h00;
		rpm = 6'h01;
		arm();
		run(1400);
		check("rechecks", n_rise, 3);
		rssi = 7'h32;
		run(1400);
		check("recovered signal", n_rise, 0);
		tod = 11'h0C8;
		rssi = 7'h0A;
		run(700);
		check("after window", n_rise, 0);
		rpm = 6'h00;
	endtask

	task automatic t_allday();
		csh = 5'h00;
		cph = 5'h00;
		cpm = 6'h00;
		do_reset();
		run(300);
		check("all day window", n_rise, 1);
	endtask

	task automatic t_on_off();
		cm = MODE_ON;
		rssi = 7'h5A;
		spray = 7'h05;
		run(20);
		check("on mode", {pump, spin}, 2'h3);
		cm = MODE_OFF;
		run(2);
		check("off aborts", {pump, spin, busy}, 0);
		run(200);
		check("off stays", n_spin + n_pump, 0);
		// the spare mode code must behave as off
		cm = mode_t'(2'h3);
		run(200);
		check("spare mode code", n_spin + n_pump, 0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{fail_count, total_checks} = '0;
		um = MODE_OFF;
		lm = MODE_OFF;
		cm = MODE_OFF;
		{tod, rssi, spray, rph, rpm} = '0;
		{upw, lpw, uoff, lthr, cthr} = {7'h07, 7'h07, 5'h02, 7'h1E, 7'h14};
		{amb, mir} = {12'h100, 12'h110};
		{ush, usm, uph, upm, lsh, lsm, lph, lpm} = {5'h12, 6'h00, 5'h06, 6'h00, 5'h12, 6'h00, 5'h06, 6'h00};
		{csh, csm, cph, cpm} = {5'h01, 6'h00, 5'h01, 6'h1E};
		do_reset();
		t_power();
		t_heat_auto();
		t_cycle();
		t_thresh();
		t_repeat();
		t_allday();
		t_on_off();
		stop_test();
	end

	// the tests take about 12000 cycles
	initial begin
		#200000;
		fail_count++;
		stop_test();
	end
endmodule
`default_nettype wire
